// File: common/tdmhp_cfg.svh
// Offsets, field positions and reset values of the link and host port block
`ifndef TDMHP_CFG_SVH
`define TDMHP_CFG_SVH
// Register offsets on the host port
`define TDMHP_OFS_GEN   6'h0F
`define TDMHP_OFS_CC    6'h14
`define TDMHP_OFS_TIM   6'h15
// Reset value of every register and of unmapped reads
`define TDMHP_RST_VAL   8'h00
// Fields of general_control
`define TDMHP_GEN_SRST  0
`define TDMHP_GEN_SPLIT 1
// Fields of link_timing_control
`define TDMHP_TIM_CC    0
`define TDMHP_TIM_V1    1
`define TDMHP_TIM_V2    2
// Frame geometry: 32 channels of 8 bits, two clock edges per bit
`define TDMHP_CNT_MAX   9'h1FF
`define TDMHP_CH_CC     5'h01
`define TDMHP_CH_V1     5'h02
`define TDMHP_CH_V2     5'h03
`define TDMHP_LAST_BIT  3'h7
`endif

// File: common/tdmhp_pkg.sv
// Types shared by the link and host port block
package tdmhp_pkg;
  // Host port sequencer states
  typedef enum logic [1:0] {
    HP_IDLE = 2'b00,
    HP_CMD  = 2'b01,
    HP_DATA = 2'b10,
    HP_DONE = 2'b11
  } tdmhp_state_t;
  // Command/address byte, bit 7 first
  typedef struct packed {
    logic       rd;
    logic       spare;
    logic [5:0] addr;
  } tdmhp_cmd_t;
  // Channel enables carried into the link domain
  typedef struct packed {
    logic v2;
    logic v1;
    logic cc;
  } tdmhp_chen_t;
  // Pin pair of a two-way pin
  typedef struct packed {
    logic dout;
    logic oe;
  } tdmhp_drv_t;
endpackage

// File: verilog/tdmhp_core.sv
// TDM link and serial host port of the telephone circuit
`timescale 1ns/1ns
`include "tdmhp_cfg.svh"

module tdmhp_core
  import tdmhp_pkg::*;
(
  input  wire logic       clk_in,                // System clock, 10 MHz
  input  wire logic       rst_n_in,              // Power-up reset, active low
  input  wire logic       hp_cs_n_in,            // Host chip select, active low
  input  wire logic       hp_sclk_in,            // Host serial clock
  input  wire logic       serial_data_primary_in,  // Primary data pin level
  output logic            serial_data_primary_out, // Primary data drive value
  output logic            serial_data_primary_oe_out, // Primary drive enable
  output logic            serial_data_secondary_out, // Secondary drive value
  output logic            serial_data_secondary_oe_out, // Secondary enable
  output logic [7:0]      general_control_out,   // general_control contents
  input  wire logic       tdm_bit_clock_2x_in,   // Link clock, twice bit rate
  input  wire logic       tdm_frame_pulse_n_in,  // Frame pulse, active low
  input  wire logic       tdm_input_stream_in,   // Link input stream
  output logic            tdm_output_stream_out, // Link output stream value
  output logic            tdm_output_stream_oe_out, // Link output enable
  input  wire logic [7:0] pcm_tx_in,             // Codec PCM, link domain
  output logic [7:0]      pcm_rx_out,            // Received PCM, link domain
  output logic            pcm_rx_valid_out       // PCM byte strobe, link domain
);

  // Read mux of the register map; unmapped addresses read as zero
  function automatic logic [7:0] rd_mux(input logic [5:0] a,
                                        input logic [7:0] g,
                                        input logic [7:0] c,
                                        input logic [7:0] t);
    logic [7:0] v;
    v = `TDMHP_RST_VAL;
    case (a)
      `TDMHP_OFS_GEN: v = g;
      `TDMHP_OFS_CC:  v = c;
      `TDMHP_OFS_TIM: v = t;
      default:        v = `TDMHP_RST_VAL;
    endcase
    return v;
  endfunction

  // ---------------- System domain ----------------

  // Host pins synchronisers, three stages for clock and data so the edge detect skips stage one; two for chip select
  logic [2:0] sclk_s_r;
  logic [1:0] cs_s_r;
  logic [2:0] din_s_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_s_r <= 3'h7;
      cs_s_r   <= 2'h3;
      din_s_r  <= 3'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], hp_sclk_in};
      cs_s_r   <= {cs_s_r[0], hp_cs_n_in};
      din_s_r  <= {din_s_r[1:0], serial_data_primary_in};
    end
  end

  // Falling serial clock edge, data taken at matching depth
  wire sclk_fall = sclk_s_r[2] & ~sclk_s_r[1];
  wire cs_high   = cs_s_r[1];
  wire din_bit   = din_s_r[2];

  // Registers and host port state
  tdmhp_state_t st_r, st_nxt;
  logic [2:0] bit_r;
  logic [7:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  tdmhp_cmd_t cmd_r;
  logic [7:0] gen_r;
  logic [7:0] tim_r;
  logic [7:0] cc_host_r;
  logic       cc_host_tgl_r;
  logic [7:0] cc_rx_r;
  tdmhp_drv_t pri_r;
  tdmhp_drv_t sec_r;

  // Decode of the current serial bit; LSB arrives first
  wire [7:0]  rx_byte   = {din_bit, rx_sh_r[7:1]};
  wire        last_bit  = (bit_r == `TDMHP_LAST_BIT);
  tdmhp_cmd_t cmd_now;
  assign cmd_now = rx_byte;
  wire [7:0]  rd_val    = rd_mux(cmd_now.addr, gen_r, cc_rx_r, tim_r);
  wire        wr_commit = (st_r == HP_DATA) && sclk_fall && last_bit
                          && !cmd_r.rd;
  wire        split     = gen_r[`TDMHP_GEN_SPLIT];
  wire        soft_rst  = gen_r[`TDMHP_GEN_SRST];

  // Host port sequencer next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      HP_IDLE: if (!cs_high) st_nxt = HP_CMD;
      HP_CMD:  if (sclk_fall && last_bit) st_nxt = HP_DATA;
      HP_DATA: if (sclk_fall && last_bit) st_nxt = HP_DONE;
      HP_DONE: st_nxt = HP_DONE;
      default: st_nxt = HP_IDLE;
    endcase
    if (cs_high) st_nxt = HP_IDLE;
  end

  // Sequencer, bit counter and shift registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r    <= HP_IDLE;
      bit_r   <= 3'h0;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      cmd_r   <= '0;
    end else begin
      st_r <= st_nxt;
      if (cs_high || st_r == HP_IDLE) begin
        bit_r <= 3'h0;
      end else if (sclk_fall && st_r != HP_DONE) begin
        bit_r   <= bit_r + 3'h1;
        rx_sh_r <= rx_byte;
        if (st_r == HP_CMD && last_bit) begin
          cmd_r   <= cmd_now;
          tx_sh_r <= rd_val;
        end else begin
          tx_sh_r <= {1'b0, tx_sh_r[7:1]};
        end
      end
    end
  end

  // Serial output drive; the output bit follows the sampling edge
  // Drives from the start of a read data byte until chip select rises, so the host never
  // meets a driven pin during the command byte.
  wire        rd_phase  = (st_r == HP_DATA || st_r == HP_DONE) &&
                          cmd_r.rd;
  wire        load_rd   = (st_r == HP_CMD) && sclk_fall && last_bit &&
                          cmd_now.rd;
  wire        drv_on    = !cs_high && (rd_phase || load_rd);
  wire        next_bit  = load_rd ? rd_val[0] :
                          (sclk_fall && st_r == HP_DATA) ? tx_sh_r[1] :
                          pri_r.dout | sec_r.dout;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pri_r <= '0;
      sec_r <= '0;
    end else begin
      pri_r.dout <= split ? 1'b0 : next_bit;
      pri_r.oe   <= split ? 1'b0 : drv_on;
      sec_r.dout <= split ? next_bit : 1'b0;
      sec_r.oe   <= split ? drv_on : 1'b0;
    end
  end

  // Cross from link domain: received control byte with toggle
  logic [7:0] cc_rx_lk_r;
  logic       cc_rx_tgl_r;
  logic [2:0] cc_rx_tgl_s_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cc_rx_tgl_s_r <= 3'h0;
    end else begin
      cc_rx_tgl_s_r <= {cc_rx_tgl_s_r[1:0], cc_rx_tgl_r};
    end
  end
  wire cc_rx_evt = cc_rx_tgl_s_r[2] ^ cc_rx_tgl_s_r[1];

  // Register writes; software reset clears the map on the next cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gen_r         <= `TDMHP_RST_VAL;
      tim_r         <= `TDMHP_RST_VAL;
      cc_host_r     <= `TDMHP_RST_VAL;
      cc_host_tgl_r <= 1'b0;
      cc_rx_r       <= `TDMHP_RST_VAL;
    end else if (soft_rst) begin
      gen_r     <= `TDMHP_RST_VAL;
      tim_r     <= `TDMHP_RST_VAL;
      cc_host_r <= `TDMHP_RST_VAL;
      cc_rx_r   <= `TDMHP_RST_VAL;
    end else begin
      if (cc_rx_evt) cc_rx_r <= cc_rx_lk_r;
      if (wr_commit) begin
        case (cmd_r.addr)
          `TDMHP_OFS_GEN: gen_r <= rx_byte;
          `TDMHP_OFS_TIM: tim_r <= rx_byte;
          `TDMHP_OFS_CC: begin
            cc_host_r     <= rx_byte;
            cc_host_tgl_r <= ~cc_host_tgl_r;
          end
          default: ;
        endcase
      end
    end
  end

  // Pin and register outputs
  assign serial_data_primary_out      = pri_r.dout;
  assign serial_data_primary_oe_out   = pri_r.oe;
  assign serial_data_secondary_out    = sec_r.dout;
  assign serial_data_secondary_oe_out = sec_r.oe;
  assign general_control_out          = gen_r;

  // ---------------- Link domain ----------------

  // Enables are quasi-static levels, two flip-flops each
  tdmhp_chen_t en_s1_r, en_s2_r;
  logic [2:0]  cc_tgl_s_r;
  always_ff @(negedge tdm_bit_clock_2x_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_s1_r    <= '0;
      en_s2_r    <= '0;
      cc_tgl_s_r <= 3'h0;
    end else begin
      en_s1_r    <= {tim_r[`TDMHP_TIM_V2], tim_r[`TDMHP_TIM_V1],
                     tim_r[`TDMHP_TIM_CC]};
      en_s2_r    <= en_s1_r;
      cc_tgl_s_r <= {cc_tgl_s_r[1:0], cc_host_tgl_r};
    end
  end

  // Frame position counter, restarted by a valid frame pulse
  logic [8:0] cnt_r;
  logic       synced_r;
  logic       cc_ack_r;
  wire        frame    = !tdm_frame_pulse_n_in;
  wire [8:0]  cnt_nxt  = frame ? 9'h000 : cnt_r + 9'h001;
  wire [4:0]  ch_nxt   = cnt_nxt[8:4];
  wire [2:0]  bit_nxt  = cnt_nxt[3:1];
  wire        cell_beg = !cnt_nxt[0];
  wire        v1_en    = en_s2_r.v1;
  wire        v2_en    = en_s2_r.v2 && !v1_en;
  wire        v_ch     = (ch_nxt == `TDMHP_CH_V1 && v1_en) ||
                         (ch_nxt == `TDMHP_CH_V2 && v2_en);
  wire        cc_pend  = cc_tgl_s_r[2] ^ cc_ack_r;

  logic [7:0] cc_tx_r;
  logic [7:0] pcm_tx_r;
  logic [7:0] lk_sh_r;
  always_ff @(negedge tdm_bit_clock_2x_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r    <= `TDMHP_CNT_MAX;
      synced_r <= 1'b0;
      cc_tx_r  <= `TDMHP_RST_VAL;
      cc_ack_r <= 1'b0;
      pcm_tx_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
      if (frame) begin
        synced_r <= 1'b1;
        pcm_tx_r <= pcm_tx_in;
        // Whole byte swap at the boundary, never mid transfer
        if (cc_pend) begin
          cc_tx_r  <= cc_host_r;
          cc_ack_r <= ~cc_ack_r;
        end
      end
    end
  end

  // Output stream: drive at cell start, MSB first
  logic tx_bit_r, tx_oe_r;
  always_ff @(negedge tdm_bit_clock_2x_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_bit_r <= 1'b0;
      tx_oe_r  <= 1'b0;
    end else if (synced_r || frame) begin
      if (cell_beg) begin
        tx_bit_r <= 1'b0;
        tx_oe_r  <= 1'b0;
        if (ch_nxt == `TDMHP_CH_CC) begin
          tx_bit_r <= cc_tx_r[3'h7 - bit_nxt];
          tx_oe_r  <= en_s2_r.cc;
        end else if (ch_nxt == `TDMHP_CH_V1 ||
                     ch_nxt == `TDMHP_CH_V2) begin
          tx_bit_r <= v_ch & pcm_tx_r[3'h7 - bit_nxt];
          tx_oe_r  <= 1'b1;
        end
      end
    end
  end

  // Input stream: sample mid cell, collect bytes MSB first
  logic [7:0] pcm_rx_r;
  logic       pcm_vld_r;
  wire  [7:0] lk_byte = {lk_sh_r[6:0], tdm_input_stream_in};
  always_ff @(negedge tdm_bit_clock_2x_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lk_sh_r     <= 8'h00;
      cc_rx_lk_r  <= `TDMHP_RST_VAL;
      cc_rx_tgl_r <= 1'b0;
      pcm_rx_r    <= 8'h00;
      pcm_vld_r   <= 1'b0;
    end else begin
      pcm_vld_r <= 1'b0;
      if (synced_r && !frame && !cell_beg) begin
        lk_sh_r <= lk_byte;
        if (bit_nxt == `TDMHP_LAST_BIT) begin
          if (ch_nxt == `TDMHP_CH_CC) begin
            cc_rx_lk_r  <= lk_byte;
            cc_rx_tgl_r <= ~cc_rx_tgl_r;
          end
          if (v_ch) begin
            pcm_rx_r  <= lk_byte;
            pcm_vld_r <= 1'b1;
          end
        end
      end
    end
  end

  assign tdm_output_stream_out    = tx_bit_r;
  assign tdm_output_stream_oe_out = tx_oe_r;
  assign pcm_rx_out               = pcm_rx_r;
  assign pcm_rx_valid_out         = pcm_vld_r;

endmodule // tdmhp_core

// File: test/tdmhp_core_asserts.sv
// Concurrent checks on the ports of the link and host port block
`timescale 1ns/1ns
`include "tdmhp_cfg.svh"
module tdmhp_core_asserts (
  input wire logic       clk_in,                       // System clock
  input wire logic       rst_n_in,                     // Async reset
  input wire logic       hp_cs_n_in,                   // Chip select
  input wire logic       serial_data_primary_oe_out,   // Primary enable
  input wire logic       serial_data_secondary_oe_out, // Secondary enable
  input wire logic [7:0] general_control_out,          // Control contents
  input wire logic       tdm_bit_clock_2x_in,          // Link clock
  input wire logic       tdm_frame_pulse_n_in,         // Frame pulse
  input wire logic       tdm_output_stream_out,        // Link output value
  input wire logic       tdm_output_stream_oe_out,     // Link output enable
  input wire logic       pcm_rx_valid_out              // Voice byte strobe
);
  logic [8:0] lcnt_r;
  logic [8:0] lcnt_nxt;
  logic       synced_r;
  wire  [4:0] chan  = lcnt_r[8:4];
  wire        voice = (chan == `TDMHP_CH_V1) || (chan == `TDMHP_CH_V2);
  wire        used  = voice || (chan == `TDMHP_CH_CC);
  // Own frame position; it means nothing until the first valid pulse
  assign lcnt_nxt = tdm_frame_pulse_n_in ? lcnt_r + 9'h001 : 9'h000;
  always_ff @(negedge tdm_bit_clock_2x_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lcnt_r   <= 9'h000;
      synced_r <= 1'h0;
    end else begin
      lcnt_r   <= lcnt_nxt;
      synced_r <= synced_r | ~tdm_frame_pulse_n_in;
    end
  end
  sequence s_cs_idle;
    hp_cs_n_in [*5];
  endsequence
  sequence s_mid_cell;
    synced_r && used && lcnt_r[0];
  endsequence
  a_cs_high_quiet: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    s_cs_idle |-> !serial_data_primary_oe_out && !serial_data_secondary_oe_out)
    else $error("data pin driven while chip select high");
  a_split_input_only: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    general_control_out[`TDMHP_GEN_SPLIT] |-> !serial_data_primary_oe_out)
    else $error("primary pin driven in split mode");
  a_secondary_released: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !general_control_out[`TDMHP_GEN_SPLIT] |-> !serial_data_secondary_oe_out)
    else $error("secondary pin driven without split");
  a_reset_quiet: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> general_control_out == `TDMHP_RST_VAL
      && !serial_data_primary_oe_out && !serial_data_secondary_oe_out)
    else $error("outputs not cleared by reset");
  a_off_slot_released: assert property (
    @(negedge tdm_bit_clock_2x_in) disable iff (!rst_n_in)
    synced_r && !used |-> !tdm_output_stream_oe_out)
    else $error("unused channel driven");
  a_voice_slot_driven: assert property (
    @(negedge tdm_bit_clock_2x_in) disable iff (!rst_n_in)
    synced_r && voice |-> tdm_output_stream_oe_out)
    else $error("voice channel released");
  a_cell_bit_holds: assert property (
    @(negedge tdm_bit_clock_2x_in) disable iff (!rst_n_in)
    s_mid_cell |-> $stable(tdm_output_stream_out) && $stable(tdm_output_stream_oe_out))
    else $error("output bit changed mid cell");
  a_rx_valid_slot: assert property (
    @(negedge tdm_bit_clock_2x_in) disable iff (!rst_n_in)
    pcm_rx_valid_out |-> synced_r && voice && lcnt_r[3:0] == 4'hF)
    else $error("voice strobe outside last bit of slot");
  a_rx_valid_pulse: assert property (
    @(negedge tdm_bit_clock_2x_in) disable iff (!rst_n_in)
    pcm_rx_valid_out |=> !pcm_rx_valid_out)
    else $error("voice strobe longer than one edge");
endmodule // tdmhp_core_asserts

bind tdmhp_core tdmhp_core_asserts u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .hp_cs_n_in(hp_cs_n_in),
  .serial_data_primary_oe_out(serial_data_primary_oe_out),
  .serial_data_secondary_oe_out(serial_data_secondary_oe_out),
  .general_control_out(general_control_out), .tdm_bit_clock_2x_in(tdm_bit_clock_2x_in),
  .tdm_frame_pulse_n_in(tdm_frame_pulse_n_in), .tdm_output_stream_out(tdm_output_stream_out),
  .tdm_output_stream_oe_out(tdm_output_stream_oe_out), .pcm_rx_valid_out(pcm_rx_valid_out));

// File: test/tdmhp_link_partner.sv
// Line transceiver model: link clock, frame pulse and channel traffic
`timescale 1ns/1ns
module tdmhp_link_partner (
  output logic            lclk_out, // Link clock, twice bit rate
  output logic            fp_n_out, // Frame pulse, active low
  output logic            din_out,  // Stream into the device
  input  wire logic       dout_in,  // Stream out of the device
  input  wire logic       oe_in,    // Device drive enable
  input  wire logic [7:0] cc_in,    // Control byte to send
  input  wire logic [7:0] v1_in,    // Voice b1 byte to send
  input  wire logic [7:0] v2_in,    // Voice b2 byte to send
  output logic [23:0]     got_out,  // Bytes seen in channels 1 to 3
  output logic [2:0]      seen_out  // Slot driven on every bit
);
  logic [8:0]  cnt = 9'h1F0;
  logic [7:0]  sh = 8'h00;
  logic        oacc = 1'h0;
  logic        fp_n_r = 1'h1;
  logic        din_r = 1'h0;
  logic [23:0] got_r = 24'h000000;
  logic [2:0]  seen_r = 3'h0;
  wire  [4:0]  ch = cnt[8:4];
  wire         used = (ch != 5'h00) && (ch < 5'h04);
  wire  [7:0]  tx = (ch == 5'h01) ? cc_in : (ch == 5'h02) ? v1_in : v2_in;
  wire  [1:0]  sl = cnt[5:4] - 2'h1;
  wire         ob = (cnt[3:0] == 4'h1) ? oe_in : oacc & oe_in;
  // Each output has a single process behind it
  assign fp_n_out = fp_n_r;
  assign din_out  = din_r;
  assign got_out  = got_r;
  assign seen_out = seen_r;
  // Free running clock of 15 ns, phase unrelated to the system clock
  initial begin
    lclk_out = 1'h1;
    #3;
    forever begin
      #8 lclk_out = 1'h0;
      #7 lclk_out = 1'h1;
    end
  end
  // Pulse once per 512 edges; send at cell start, sample mid cell
  always @(negedge lclk_out) begin
    fp_n_r <= (cnt != 9'h1FF);
    if (!cnt[0]) begin
      din_r <= used ? tx[3'h7 - cnt[3:1]] : ~din_r;
    end else if (used) begin
      sh   <= {sh[6:0], dout_in};
      oacc <= ob;
      if (cnt[3:0] == 4'hF) begin
        got_r[{sl, 3'h0} +: 8] <= {sh[6:0], dout_in};
        seen_r[sl]             <= ob;
      end
    end
    cnt <= cnt + 9'h001;
  end
endmodule // tdmhp_link_partner

// File: test/tb_tdmhp_core.sv
// Self-checking bench for the link and host port block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module tb_tdmhp_core;
  logic        clk_in = 1'h0;
  logic        rst_n_in = 1'h0;
  logic        cs_n = 1'h1;
  logic        sclk = 1'h1;
  logic        host_d = 1'h1;
  logic        host_drv = 1'h0;
  logic        split = 1'h0;
  logic [7:0]  pcm_tx = 8'h00;
  logic        p_out, p_oe, s_out, s_oe, t_out, t_oe, pcm_v, lclk, fp_n, din;
  logic [7:0]  gen, pcm_rx;
  logic [23:0] got;
  logic [2:0]  seen;
  int          n_errors = 0;
  int          checks_done = 0;
  logic        rd_now = 1'h0;
  int          n_drv = 0;
  // Pin levels: device drive wins, then the host, else the pull-up
  wire prim_w = p_oe ? p_out : (host_drv ? host_d : 1'h1);
  wire sec_w  = s_oe ? s_out : 1'h1;
  // A released link line shows the inverse, so a missing drive cannot pass
  wire line_w = t_oe ? t_out : ~t_out;
  // Any data pin drive inside a write access is counted
  always @(posedge clk_in) begin
    if (!cs_n && !rd_now && (p_oe || s_oe)) n_drv++;
  end
  tdmhp_core DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .hp_cs_n_in(cs_n), .hp_sclk_in(sclk),
    .serial_data_primary_in(prim_w), .serial_data_primary_out(p_out),
    .serial_data_primary_oe_out(p_oe), .serial_data_secondary_out(s_out),
    .serial_data_secondary_oe_out(s_oe), .general_control_out(gen),
    .tdm_bit_clock_2x_in(lclk), .tdm_frame_pulse_n_in(fp_n), .tdm_input_stream_in(din),
    .tdm_output_stream_out(t_out), .tdm_output_stream_oe_out(t_oe),
    .pcm_tx_in(pcm_tx), .pcm_rx_out(pcm_rx), .pcm_rx_valid_out(pcm_v));
  tdmhp_link_partner u_link (
    .lclk_out(lclk), .fp_n_out(fp_n), .din_out(din), .dout_in(line_w), .oe_in(t_oe),
    .cc_in(8'h1E), .v1_in(8'h2D), .v2_in(8'h71), .got_out(got), .seen_out(seen));
  // System clock, 100 ns period
  always #50 clk_in = ~clk_in;
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task report_and_stop;
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Slow serial clock (8 cycles a bit) leaves room for the pin synchronisers
  task hp_xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {wd, cmd};
    rd = 8'h00;
    rd_now = cmd[7];
    cs_n = 1'h0;
    host_drv = 1'h1;
    for (int k = 0; k < 16; k++) begin
      host_d = sh[k];
      cyc(4);
      if (k > 7) rd[k-8] = split ? sec_w : prim_w;
      sclk = 1'h0;
      if (k == 7 && cmd[7]) host_drv = 1'h0;
      cyc(4);
      sclk = 1'h1;
    end
    cyc(2);
    cs_n = 1'h1;
    host_drv = 1'h0;
    cyc(6);
  endtask
  task hp_wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    hp_xfer({2'h0, a}, d, r);
    `CHK("drive during write", 0, n_drv)
  endtask
  task hp_rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] r;
    hp_xfer({2'h2, a}, 8'h00, r);
    `CHK("read data", exp, r)
  endtask
  // Three pulses: settings cross over and one whole frame follows
  task frames;
    repeat (3) @(negedge fp_n);
    cyc(2);
  endtask
  // Main sequence
  initial begin
    cyc(16);
    rst_n_in = 1'h1;
    cyc(4);
    `CHK("primary enable", 1'h0, p_oe)
    `CHK("secondary enable", 1'h0, s_oe)
    `CHK("general control", 8'h00, gen)
    hp_rd(6'h15, 8'h00);
    hp_rd(6'h3F, 8'h00);
    hp_wr(6'h0F, 8'h02);
    split = 1'h1;
    `CHK("general control", 8'h02, gen)
    hp_rd(6'h0F, 8'h02);
    hp_wr(6'h15, 8'h01);
    hp_wr(6'h14, 8'hC6);
    frames();
    `CHK("channel one byte", 8'hC6, got[7:0])
    `CHK("channel one driven", 1'h1, seen[0])
    hp_rd(6'h14, 8'h1E);
    pcm_tx = 8'h4B;
    hp_wr(6'h15, 8'h06);
    frames();
    `CHK("channel two byte", 8'h4B, got[15:8])
    `CHK("channel three byte", 8'h00, got[23:16])
    `CHK("channel three driven", 1'h1, seen[2])
    `CHK("voice receive", 8'h2D, pcm_rx)
    hp_wr(6'h15, 8'h04);
    frames();
    `CHK("channel two byte", 8'h00, got[15:8])
    `CHK("channel three byte", 8'h4B, got[23:16])
    `CHK("voice receive", 8'h71, pcm_rx)
    `CHK("channel one driven", 1'h0, seen[0])
    hp_wr(6'h0F, 8'h01);
    split = 1'h0;
    `CHK("general control", 8'h00, gen)
    hp_rd(6'h15, 8'h00);
    hp_wr(6'h15, 8'h03);
    hp_rd(6'h15, 8'h03);
    report_and_stop;
  end
  // Watchdog; the full run takes some 2400 cycles
  initial begin
    repeat (40000) @(posedge clk_in);
    n_errors++;
    report_and_stop;
  end
endmodule // tb_tdmhp_core
